// >>> common/rwc_pkg.sv
// Constants for the reset and watchdog control block
package rwc_pkg;
	// Register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] CTRL_ADDR = 8'h60;
	localparam logic [7:0] STATUS_ADDR = 8'h54;
	// Control register fields
	localparam int PERIOD_SEL_LSB = 0;
	localparam int PERIOD_SEL_W = 3;
	localparam int ENABLE_BIT = 3;
	localparam int CHANGE_EN_BIT = 4;
	// Status register fields
	localparam int WD_FLAG_BIT = 3;
	localparam int RUNNING_BIT = 0;
	// Reset values
	localparam logic [2:0] PERIOD_SEL_RESET = 3'h0;
	localparam logic ENABLE_RESET = 1'b0;
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int STARTUP_DELAY_US = 65;
	localparam int STARTUP_CYCLES = STARTUP_DELAY_US * CLK_MHZ;
	localparam int STARTUP_CNT_W = 24;
	localparam int CHANGE_WINDOW_CYCLES = 4;
	localparam logic [2:0] CHANGE_WINDOW = 3'(CHANGE_WINDOW_CYCLES);
	// Watchdog period base is 16K oscillator cycles
	localparam int WDT_CNT_W = 22;
	localparam logic [21:0] WDT_BASE_PERIOD = 22'h00_4000;
	// Brown-out fuse code that means detector off
	localparam logic [2:0] BROWNOUT_OFF_CODE = 3'h7;
endpackage

// >>> tb/rwc_chk.sv
// Port assertions for reset and watchdog control
`timescale 1ns/1ps
`default_nettype none
module rwc_chk #(
	parameter int P_STARTUP_CYCLES = 20
) (
	// Clock, reset and sources
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_power_lost,
	input wire logic i_ext_reset_n,
	input wire logic i_brownout_low,
	input wire logic [2:0] i_brownout_level_fuse,
	input wire logic i_scan_reset_reg,
	input wire logic i_comparator_bandgap_select,
	input wire logic i_converter_enable,
	// Results
	input wire logic o_internal_reset,
	input wire logic o_source_active,
	input wire logic o_watchdog_pulse,
	input wire logic o_bandgap_on
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	property p_src; o_source_active |-> o_internal_reset; endproperty
	a_src: assert property (p_src) else $error("source without reset");
	property p_ext; !i_ext_reset_n |-> o_source_active; endproperty
	a_ext: assert property (p_ext) else $error("pin ignored");
	property p_scan; i_scan_reset_reg |-> o_source_active; endproperty
	a_scan: assert property (p_scan) else $error("scan ignored");
	property p_pwr; i_power_lost |-> o_internal_reset; endproperty
	a_pwr: assert property (p_pwr) else $error("supply loss ignored");
	property p_brownout;
		i_brownout_low && i_brownout_level_fuse != 3'h7 |-> o_source_active;
	endproperty
	a_brownout: assert property (p_brownout) else $error("brownout ignored");
	property p_pulse;
		o_watchdog_pulse |-> o_source_active ##1 (!o_watchdog_pulse && o_internal_reset);
	endproperty
	a_pulse: assert property (p_pulse) else $error("bad pulse");
	property p_hold; $past(i_resetn) && $fell(o_source_active) |-> o_internal_reset [*8]; endproperty
	a_hold: assert property (p_hold) else $error("no stretch");
	property p_bg;
		o_bandgap_on == (i_brownout_level_fuse != 3'h7 || i_comparator_bandgap_select
			|| i_converter_enable);
	endproperty
	a_bg: assert property (p_bg) else $error("bandgap wrong");
	cover property (o_watchdog_pulse);
	cover property ($fell(o_internal_reset));
	cover property (!i_ext_reset_n);
endmodule // rwc_chk
bind rwc_reset_watchdog rwc_chk #(.P_STARTUP_CYCLES(P_STARTUP_CYCLES)) u_chk (.*);
`default_nettype wire

// >>> tb/rwc_pin_model.sv
// External reset pin driver model
`timescale 1ns/1ps
`default_nettype none
module rwc_pin_model (
	// Request
	input wire logic i_hold,
	// Pin
	output logic o_pin_n
);
	assign o_pin_n = !i_hold;
endmodule // rwc_pin_model
`default_nettype wire

// >>> tb/testbench.sv
// Bench for reset and watchdog control
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_mclk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_power_lost = 1, i_brownout_low = 0;
	logic i_scan_reset_reg = 0, i_watchdog_always_on_fuse = 0, i_wdt_osc_tick = 1, i_kick = 0;
	logic i_comparator_bandgap_select = 0, i_converter_enable = 0, hold = 0, i_ext_reset_n;
	logic o_internal_reset, o_source_active, o_watchdog_pulse, o_bandgap_on;
	logic [7:0] i_addr = 0, i_wdata = 0, o_rdata;
	logic [2:0] i_brownout_level_fuse = 3'h7;
	int num_errors = 0, tests_run = 0, cyc = 0, pulses = 0;
	always #5 i_mclk = !i_mclk;
	always @(negedge i_mclk) pulses += o_watchdog_pulse;
	rwc_pin_model pm (.i_hold(hold), .o_pin_n(i_ext_reset_n));
	rwc_reset_watchdog #(.P_STARTUP_CYCLES(20)) dut (.*);
	task chk(string n, logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task wait_n(int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task wrt(logic [7:0] a, d);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		wait_n(1);
		i_wr <= 0;
		wait_n(1);
	endtask
	task rdc(string n, logic [7:0] a, e);
		{i_rd, i_addr} <= {1'b1, a};
		wait_n(1);
		i_rd <= 0;
		#1 chk(n, o_rdata, e);
		wait_n(1);
	endtask
	task src_chk(int i);
		{hold, i_brownout_low, i_scan_reset_reg, i_power_lost} <= 4'b1000 >> i;
		wait_n(2);
		#1 chk("on", 8'(o_internal_reset), 8'h01);
		{hold, i_brownout_low, i_scan_reset_reg, i_power_lost} <= 4'h0;
		wait_n(10);
		#1 chk("held", 8'(o_internal_reset), 8'h01);
		wait_n(20);
		#1 chk("off", 8'(o_internal_reset), 8'h00);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			print_verdict;
		end
	end
	initial begin
		wait_n(8);
		i_resetn <= 1;
		wait_n(3);
		i_power_lost <= 0;
		wait_n(10);
		chk("por", 8'(o_internal_reset), 8'h01);
		wait_n(20);
		rdc("ctrl", 8'h60, 8'h00);
		for (int i = 0; i < 8; i++) begin
			{i_brownout_level_fuse[0], i_comparator_bandgap_select, i_converter_enable} <= ~3'(i);
			wait_n(1);
			#1 chk("bandgap", 8'(o_bandgap_on), 8'(i != 3));
		end
		for (int i = 0; i < 4; i++) src_chk(i);
		$display("sources done");
		wrt(8'h60, 8'h08);
		rdc("en", 8'h60, 8'h08);
		wrt(8'h60, 8'h18);
		rdc("window", 8'h60, 8'h18);
		wait_n(4);
		rdc("closed", 8'h60, 8'h08);
		wrt(8'h60, 8'h03);
		rdc("late", 8'h60, 8'h08);
		wrt(8'h60, 8'h18);
		wrt(8'h60, 8'h00);
		rdc("off", 8'h60, 8'h00);
		$display("sequence done");
		wrt(8'h60, 8'h08);
		wait_n(16000);
		i_kick <= 1;
		wait_n(1);
		i_kick <= 0;
		wait_n(16000);
		chk("kicked", 8'(pulses), 8'h00);
		wait_n(600);
		chk("expired", 8'(pulses), 8'h01);
		rdc("flag", 8'h54, 8'h08);
		wrt(8'h54, 8'h00);
		rdc("flag clr", 8'h54, 8'h00);
		$display("watchdog done");
		i_watchdog_always_on_fuse <= 1;
		src_chk(2);
		rdc("lvl2", 8'h60, 8'h08);
		wrt(8'h60, 8'h00);
		rdc("lvl2 keep", 8'h60, 8'h08);
		wrt(8'h60, 8'h18);
		wrt(8'h60, 8'h02);
		rdc("lvl2 per", 8'h60, 8'h0a);
		$display("level two done");
		print_verdict;
	end
endmodule // testbench
`default_nettype wire

// >>> verilog/rwc_reset_watchdog.sv
// Reset merging, startup stretching and watchdog supervision
// Operation
// - Five sources assert internal reset
// - Long external low resets without clock
// - External release waits startup delay
// - Scan reset register holds reset
// - Supply loss resets at once, delayed release
// - Enabled brown-out resets at once, delayed release
// - Watchdog pulse one clock, delay after
// - Watchdog counts dedicated oscillator ticks
// - Kick, disable, chip reset clear counter
// - Eight periods; expiry resets device
// - Fuse selects level, initial enable
// - Level one enables freely
// - Change starts with change-enable and enable
// - Level one second write within four
// - Level two always runs, reads one
// - Level two second write sets period
// - Bandgap on for detector, comparator, converter
// - Change-enable self clears after four
// - Period doubles from 16K to 2048K
// - Watchdog flag set, cleared by power-on/software
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rwc_reset_watchdog #(
	parameter int P_STARTUP_CYCLES = rwc_pkg::STARTUP_CYCLES
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Reset sources
	input wire logic i_power_lost,
	input wire logic i_ext_reset_n,
	input wire logic i_brownout_low,
	input wire logic [2:0] i_brownout_level_fuse,
	input wire logic i_scan_reset_reg,
	// Watchdog inputs
	input wire logic i_watchdog_always_on_fuse,
	input wire logic i_wdt_osc_tick,
	input wire logic i_kick,
	// Bandgap users
	input wire logic i_comparator_bandgap_select,
	input wire logic i_converter_enable,
	// Results
	output logic o_internal_reset,
	output logic o_source_active,
	output logic o_watchdog_pulse,
	output logic o_bandgap_on
);
	// Register address match, shared by write and read decode
	function automatic logic rwc_addr_hit(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		return addr == target;
	endfunction

	// Configuration decode
	logic brownout_enabled;
	logic level2;
	logic wd_running;

	// Register access decode
	logic wr_ctrl;
	logic wr_status;
	logic rd_ctrl;
	logic rd_status;
	logic wr_change_enable;
	logic window_open;
	logic wr_seq_open;
	logic wr_seq_commit;
	logic wr_enable_set;
	logic wr_flag_clear;

	// Watchdog period decode
	logic [rwc_pkg::WDT_CNT_W-1:0] wd_limit;
	logic wd_expire;
	logic wd_clear;

	// Startup delay state
	logic [rwc_pkg::STARTUP_CNT_W-1:0] delay_reg, delay_next;
	logic delay_busy;

	// Watchdog counter state
	logic [rwc_pkg::WDT_CNT_W-1:0] wd_cnt_reg, wd_cnt_next;
	logic pulse_reg, pulse_next;

	// Control register state
	logic [2:0] period_sel_reg, period_sel_next;
	logic enable_reg, enable_next;
	logic [2:0] ce_cnt_reg, ce_cnt_next;

	// Status flag state
	logic wd_flag_reg, wd_flag_next;

	// Read data state
	logic [7:0] rdata_reg, rdata_next;

	assign brownout_enabled = i_brownout_level_fuse != rwc_pkg::BROWNOUT_OFF_CODE;
	assign level2 = i_watchdog_always_on_fuse;
	assign wd_running = enable_reg | level2;

	assign wr_ctrl = i_wr && rwc_addr_hit(i_addr, rwc_pkg::CTRL_ADDR);
	assign wr_status = i_wr && rwc_addr_hit(i_addr, rwc_pkg::STATUS_ADDR);
	assign rd_ctrl = i_rd && rwc_addr_hit(i_addr, rwc_pkg::CTRL_ADDR);
	assign rd_status = i_rd && rwc_addr_hit(i_addr, rwc_pkg::STATUS_ADDR);
	assign wr_change_enable = i_wdata[rwc_pkg::CHANGE_EN_BIT];
	assign window_open = ce_cnt_reg != '0;

	// Opening write needs change-enable and enable together
	assign wr_seq_open = wr_ctrl && wr_change_enable
		&& i_wdata[rwc_pkg::ENABLE_BIT];
	// Committing write has change-enable clear, window still open
	assign wr_seq_commit = wr_ctrl && !wr_change_enable && window_open;
	// Late or plain write can only switch the watchdog on
	assign wr_enable_set = wr_ctrl && !wr_seq_open && !wr_seq_commit
		&& i_wdata[rwc_pkg::ENABLE_BIT];
	assign wr_flag_clear = wr_status && !i_wdata[rwc_pkg::WD_FLAG_BIT];

	// Any source forces reset without needing a clock edge
	always_comb begin
		o_source_active = 1'b0;
		if (i_power_lost) begin
			o_source_active = 1'b1;
		end
		if (!i_ext_reset_n) begin
			o_source_active = 1'b1;
		end
		if (brownout_enabled && i_brownout_low) begin
			o_source_active = 1'b1;
		end
		if (i_scan_reset_reg) begin
			o_source_active = 1'b1;
		end
		if (pulse_reg) begin
			o_source_active = 1'b1;
		end
	end

	// Stretch keeps reset high after every source has dropped
	assign delay_busy = delay_reg != '0;
	assign o_internal_reset = o_source_active | delay_busy;
	assign o_watchdog_pulse = pulse_reg;
	assign o_bandgap_on = brownout_enabled | i_comparator_bandgap_select
		| i_converter_enable;
	assign o_rdata = rdata_reg;

	// Startup delay counter, reloaded while any source is active
	always_comb begin
		delay_next = delay_reg;
		if (o_source_active) begin
			delay_next = P_STARTUP_CYCLES[rwc_pkg::STARTUP_CNT_W-1:0];
		end else if (delay_busy) begin
			delay_next = delay_reg - 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			delay_reg <= '0;
		end else begin
			delay_reg <= delay_next;
		end
	end

	// Period limit doubles per code step
	always_comb begin
		wd_limit = (rwc_pkg::WDT_BASE_PERIOD << period_sel_reg) - 1'b1;
	end

	assign wd_clear = o_internal_reset || !wd_running || i_kick;
	assign wd_expire = i_wdt_osc_tick && (wd_cnt_reg >= wd_limit);

	// Watchdog counter and expiry pulse
	always_comb begin
		wd_cnt_next = wd_cnt_reg;
		pulse_next = 1'b0;
		if (wd_clear) begin
			wd_cnt_next = '0;
		end else if (wd_expire) begin
			wd_cnt_next = '0;
			pulse_next = 1'b1;
		end else if (i_wdt_osc_tick) begin
			wd_cnt_next = wd_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			wd_cnt_reg <= '0;
			pulse_reg <= 1'b0;
		end else begin
			wd_cnt_reg <= wd_cnt_next;
			pulse_reg <= pulse_next;
		end
	end

	// Control register with timed change sequence
	always_comb begin
		period_sel_next = period_sel_reg;
		enable_next = enable_reg;
		ce_cnt_next = ce_cnt_reg;
		if (window_open) begin
			ce_cnt_next = ce_cnt_reg - 1'b1;
		end
		if (o_internal_reset) begin
			period_sel_next = rwc_pkg::PERIOD_SEL_RESET;
			enable_next = rwc_pkg::ENABLE_RESET;
			ce_cnt_next = '0;
		end else if (wr_seq_open) begin
			ce_cnt_next = rwc_pkg::CHANGE_WINDOW;
			enable_next = 1'b1;
		end else if (wr_seq_commit) begin
			ce_cnt_next = '0;
			period_sel_next = i_wdata[rwc_pkg::PERIOD_SEL_LSB +: rwc_pkg::PERIOD_SEL_W];
			if (!level2) begin
				enable_next = i_wdata[rwc_pkg::ENABLE_BIT];
			end
		end else if (wr_enable_set) begin
			enable_next = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			period_sel_reg <= rwc_pkg::PERIOD_SEL_RESET;
			enable_reg <= rwc_pkg::ENABLE_RESET;
			ce_cnt_reg <= '0;
		end else begin
			period_sel_reg <= period_sel_next;
			enable_reg <= enable_next;
			ce_cnt_reg <= ce_cnt_next;
		end
	end

	// Watchdog reset flag; hardware set beats software clear
	always_comb begin
		wd_flag_next = wd_flag_reg;
		if (i_power_lost) begin
			wd_flag_next = 1'b0;
		end else if (pulse_reg) begin
			wd_flag_next = 1'b1;
		end else if (wr_flag_clear) begin
			wd_flag_next = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			wd_flag_reg <= 1'b0;
		end else begin
			wd_flag_reg <= wd_flag_next;
		end
	end

	// Read data, one cycle after the strobe, zero otherwise
	always_comb begin
		rdata_next = 8'h00;
		if (rd_ctrl) begin
			rdata_next[rwc_pkg::PERIOD_SEL_LSB +: rwc_pkg::PERIOD_SEL_W] = period_sel_reg;
			rdata_next[rwc_pkg::ENABLE_BIT] = wd_running;
			rdata_next[rwc_pkg::CHANGE_EN_BIT] = window_open;
		end else if (rd_status) begin
			rdata_next[rwc_pkg::WD_FLAG_BIT] = wd_flag_reg;
			rdata_next[rwc_pkg::RUNNING_BIT] = wd_running;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
endmodule // rwc_reset_watchdog
`default_nettype wire
